// [core/eip_dev.sv]
// Notes on behaviour
// R1: Type 1011 write targets 16-byte ID page
// R2: Word bit 7 zero; bits 3:0 pick byte
// R3: Locked page: data bytes not acknowledged, unchanged
// R4: Lock command: type 1011, word bit 7 set
// R5: Lock data needs bit 1 set
// R6: Lock is permanent, page becomes read-only; the model clears id_locked again on reset
// R7: Reads via dummy write then repeated Start
// R8: Master never reads past page end
// R9: Probe byte acked unlocked, not acked locked
// R10: Start aborts command logic, nothing executed
// R11: Stop after abort returns to standby
// R12: Shipped contents read as ff
// R13: Traffic ignored in reset, standby after
// R14: Pointer low four bits wrap in page
// R15: Answer only when chip-select bit matches pin
// R16: No address acknowledge while programming
// R17: Lock blocks writes only, reads stay
`timescale 1ns/1ps
module eip_dev
    import eip_pkg::*;
#(
    parameter int WR_CYCLES = TWR_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    eip_if.slave bus,
    input wire logic chip_select_pin_bit,
    output logic id_locked,
    output logic prog_busy
);

    typedef enum logic [2:0] {
        D_IDLE = 3'b000,
        D_ADDR = 3'b001,
        D_WORD = 3'b010,
        D_WDATA = 3'b011,
        D_RDATA = 3'b100
    } eip_dstate_e;

    eip_dstate_e state;
    logic [1:0] scl_ff;
    logic [1:0] sda_ff;
    logic [1:0] cs_ff;
    logic scl_d;
    logic sda_d;
    logic [3:0] bitcnt;
    logic [7:0] shift;
    logic [7:0] tx;
    logic sda_low;
    logic mack;
    logic [3:0] ptr;
    logic lock_cmd;
    logic lock_arm;
    logic [ID_PAGE_BYTES-1:0] mask;
    logic [7:0] wbuf [ID_PAGE_BYTES];
    logic [7:0] page [ID_PAGE_BYTES];
    logic [31:0] busy_cnt;

    wire scl_s = scl_ff[1];
    wire sda_s = sda_ff[1];
    wire cs_s = cs_ff[1];
    wire start_det = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_det = scl_s & scl_d & ~sda_d & sda_s;
    wire rise = scl_s & ~scl_d;
    wire fall = ~scl_s & scl_d;
    wire ack_slot = fall & (bitcnt == 4'd8);
    wire slot_end = fall & (bitcnt == 4'd9);
    wire type_ok = shift[7:4] == TYPE_ID_PAGE;                      // [R1]
    wire cs_ok = shift[ADDR_CS_BIT] == cs_s;                         // [R15]
    wire addr_hit = type_ok & cs_ok & ~prog_busy;                    // [R16]
    wire is_read = shift[ADDR_RW_BIT];
    wire store_ok = ~id_locked & ~lock_cmd;
    wire [7:0] next_rd = page[ptr];                                  // [R17]
    wire commit = stop_det & ((|mask) | lock_arm);                   // [R11]
    wire mid_bit = (bitcnt != 4'd0) & (bitcnt < 4'd8);

    assign bus.s_sda_o = 1'b0;
    assign bus.s_sda_oe = sda_low;
    assign prog_busy = busy_cnt != 32'h0;

    // Pins cross into the clock domain through two flops each
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scl_ff <= 2'h3;
            sda_ff <= 2'h3;
            cs_ff <= 2'h0;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_ff <= {scl_ff[0], bus.scl};
            sda_ff <= {sda_ff[0], bus.sda};
            cs_ff <= {cs_ff[0], chip_select_pin_bit};
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    // Bit counter: 1..8 count data bits on rise, 8..9 frame the ack slot.
    // The fall that closes a Start leaves the counter at zero untouched.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= D_IDLE;                                         // [R13]
            bitcnt <= 4'h0;
            shift <= 8'h0;
            mack <= 1'b1;
        end else if (start_det) begin
            state <= D_ADDR;                                         // [R10]
            bitcnt <= 4'h0;
        end else if (stop_det) begin
            state <= D_IDLE;                                         // [R11]
        end else if (state != D_IDLE) begin
            if (rise && bitcnt < 4'd8) begin
                shift <= {shift[6:0], sda_s};
                bitcnt <= bitcnt + 4'd1;
            end else if (rise && bitcnt == 4'd8) begin
                mack <= sda_s;
                bitcnt <= 4'd9;
            end else if (slot_end) begin
                bitcnt <= 4'h0;
                if (state == D_RDATA && mack) begin
                    state <= D_IDLE;
                end
            end else if (ack_slot) begin
                case (state)
                    D_ADDR: begin
                        if (!addr_hit) begin
                            state <= D_IDLE;
                        end else if (is_read) begin
                            state <= D_RDATA;                        // [R7]
                            mack <= 1'b0;
                        end else begin
                            state <= D_WORD;
                        end
                    end
                    D_WORD: state <= D_WDATA;
                    default: state <= state;
                endcase
            end
        end
    end

    // Ack driver and read shifter change only while the clock is low
    always_ff @(posedge aclk) begin
        if (!aresetn || start_det || stop_det) begin
            sda_low <= 1'b0;
            tx <= ERASED_BYTE;
        end else if (state == D_RDATA && fall && mid_bit) begin
            sda_low <= ~tx[6];
            tx <= {tx[6:0], 1'b1};
        end else if (ack_slot) begin
            case (state)
                D_ADDR: sda_low <= addr_hit;
                D_WORD: sda_low <= 1'b1;
                D_WDATA: sda_low <= ~id_locked;                      // [R3] [R9]
                default: sda_low <= 1'b0;
            endcase
        end else if (slot_end) begin
            sda_low <= (state == D_RDATA) & ~mack & ~next_rd[7];
            tx <= next_rd;
        end
    end

    // Pointer, lock capture and the pending write buffer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ptr <= 4'h0;
            lock_cmd <= 1'b0;
            lock_arm <= 1'b0;
            mask <= '0;
        end else if (start_det) begin
            lock_arm <= 1'b0;                                        // [R10]
            mask <= '0;
        end else if (ack_slot && state == D_WORD) begin
            lock_cmd <= shift[LOCK_SELECT_BIT];                      // [R4]
            if (!shift[LOCK_SELECT_BIT]) begin
                ptr <= shift[3:0];                                   // [R2]
            end
        end else if (ack_slot && state == D_WDATA) begin
            if (lock_cmd && !id_locked && shift[LOCK_DATA_BIT]) begin
                lock_arm <= 1'b1;                                    // [R5]
            end
            if (store_ok) begin
                mask[ptr] <= 1'b1;
                ptr <= ptr + 4'd1;                                   // [R14]
            end
        end else if (slot_end && state == D_RDATA && !mack) begin
            ptr <= ptr + 4'd1;
        end
    end

    always_ff @(posedge aclk) begin
        if (ack_slot && state == D_WDATA && store_ok) begin
            wbuf[ptr] <= shift;
        end
    end

    // Page cells and lock bit leave reset in the shipped state; the
    // write cycle holds off new addresses until the timer runs out.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < ID_PAGE_BYTES; i++) begin
                page[i] <= ERASED_BYTE;                              // [R12]
            end
            id_locked <= 1'b0;
            busy_cnt <= 32'h0;
        end else if (commit) begin
            for (int i = 0; i < ID_PAGE_BYTES; i++) begin
                if (mask[i]) begin
                    page[i] <= wbuf[i];
                end
            end
            if (lock_arm) begin
                id_locked <= 1'b1;                                   // [R6]
            end
            busy_cnt <= 32'(WR_CYCLES);
        end else if (prog_busy) begin
            busy_cnt <= busy_cnt - 32'h1;
        end
    end

endmodule // eip_dev

// [core/eip_host.sv]
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module eip_host
    import eip_pkg::*;
#(
    parameter int QTR = QTR_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    eip_if.master bus,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    typedef enum logic [3:0] {
        H_IDLE = 4'b0000,
        H_START = 4'b0001,
        H_AW = 4'b0010,
        H_WORD = 4'b0011,
        H_WDATA = 4'b0100,
        H_RSTART = 4'b0101,
        H_AR = 4'b0110,
        H_RDATA = 4'b0111,
        H_PSTART = 4'b1000,
        H_STOP = 4'b1001
    } eip_hstate_e;

    eip_hstate_e state;
    eip_op_e op;
    logic cmd_cs;
    logic [3:0] cmd_ofs;
    logic [1:0] cmd_len;
    logic [31:0] txdata;
    logic [31:0] rxdata;
    logic busy, done, addr_nack, data_nack;
    logic [15:0] qcnt;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [1:0] cnt;
    logic [7:0] rxsh;
    logic nack_q;
    logic scl_l, sda_l;
    logic [1:0] sda_ff;

    // AXI4-Lite: address and data are taken together, one write at a time
    wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    wire rd_go = s_axi_arvalid & ~s_axi_rvalid;
    wire wr_cmd = s_axi_awaddr == REG_CMD;
    wire wr_tx = s_axi_awaddr == REG_TXDATA;
    wire wr_ro = (s_axi_awaddr == REG_RXDATA) | (s_axi_awaddr == REG_STATUS);
    wire [1:0] new_op = s_axi_wdata[CMD_OP_LSB +: 2];
    wire [3:0] new_ofs = s_axi_wdata[CMD_OFS_LSB +: 4];
    wire [1:0] new_len = s_axi_wdata[CMD_LEN_LSB +: 2];
    wire [4:0] rd_end = {1'b0, new_ofs} + {3'b000, new_len};
    wire rd_over = (new_op == OP_READ) & (rd_end > {1'b0, LAST_OFFSET});    // [R8]
    wire cmd_ok = wr_cmd & ~busy & (&s_axi_wstrb[1:0]) & ~rd_over;
    wire launch = wr_go & cmd_ok;
    wire wr_ok = (wr_cmd & cmd_ok) | wr_tx | wr_ro;
    wire [31:0] status_w = {28'h0, data_nack, addr_nack, done, busy};
    wire [31:0] cmd_w = {22'h0, cmd_len, cmd_ofs, 1'b0, cmd_cs, op};
    wire [31:0] rd_word = (s_axi_araddr == REG_CMD) ? cmd_w :
                          (s_axi_araddr == REG_TXDATA) ? txdata :
                          (s_axi_araddr == REG_RXDATA) ? rxdata : status_w;
    wire rd_map = s_axi_araddr[1:0] == 2'b00;

    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= 32'h0;
        end else begin
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_map ? rd_word : 32'h0;
                s_axi_rresp <= rd_map ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            txdata <= 32'h0;
        end else if (wr_go && wr_tx) begin
            for (int i = 0; i < 4; i++) begin
                if (s_axi_wstrb[i]) begin
                    txdata[i*8 +: 8] <= s_axi_wdata[i*8 +: 8];
                end
            end
        end
    end

    // Symbol timing: each START, STOP or bit is four quarter periods
    wire qtick = busy & (qcnt == 16'(QTR - 1));
    wire sym_end = qtick & (q == 2'd3);
    wire is_start = (state == H_START) | (state == H_RSTART) | (state == H_PSTART);
    wire is_stop = state == H_STOP;
    wire is_byte = busy & ~is_start & ~is_stop;
    wire last = cnt == cmd_len;
    wire [1:0] wlast = (op == OP_WRITE) ? cmd_len : 2'd0;
    wire [7:0] word_b = (op == OP_LOCK) ? LOCK_WORD : {4'h0, cmd_ofs};      // [R2] [R4]
    wire [7:0] cur_byte = (state == H_AW) ? {TYPE_ID_PAGE, cmd_cs, 3'b000} :
                          (state == H_AR) ? {TYPE_ID_PAGE, cmd_cs, 3'b001} :
                          (state == H_WORD) ? word_b :
                          (state == H_WDATA) ? txdata[{cnt, 3'b000} +: 8] : ERASED_BYTE;
    wire bit_val = (bitn < 4'd8) ? cur_byte[3'd7 - bitn[2:0]] :
                   ((state == H_RDATA) ? last : 1'b1);
    wire scl_hi = (q == 2'd1) | (q == 2'd2);
    wire next_scl = ~busy | is_stop ? (q != 2'd0) | ~busy : scl_hi;
    wire next_sda = ~busy ? 1'b1 : is_start ? (q < 2'd2) : is_stop ? (q >= 2'd2) : bit_val;
    wire sda_s = sda_ff[1];

    assign bus.m_scl_o = 1'b0;
    assign bus.m_scl_oe = ~scl_l;
    assign bus.m_sda_o = 1'b0;
    assign bus.m_sda_oe = ~sda_l;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sda_ff <= 2'h3;
            scl_l <= 1'b1;
            sda_l <= 1'b1;
            qcnt <= 16'h0;
        end else begin
            sda_ff <= {sda_ff[0], bus.sda};
            scl_l <= next_scl;
            sda_l <= next_sda;
            qcnt <= (qtick || !busy) ? 16'h0 : qcnt + 16'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= H_IDLE;
            busy <= 1'b0;
            done <= 1'b0;
            addr_nack <= 1'b0;
            data_nack <= 1'b0;
            op <= OP_WRITE;
            cmd_cs <= 1'b0;
            cmd_ofs <= 4'h0;
            cmd_len <= 2'h0;
            q <= 2'h0;
            bitn <= 4'h0;
            cnt <= 2'h0;
            rxsh <= 8'h0;
            nack_q <= 1'b0;
            rxdata <= 32'h0;
        end else if (launch) begin
            state <= H_START;
            busy <= 1'b1;
            done <= 1'b0;
            addr_nack <= 1'b0;
            data_nack <= 1'b0;
            op <= eip_op_e'(new_op);
            cmd_cs <= s_axi_wdata[CMD_CS_BIT];
            cmd_ofs <= new_ofs;
            cmd_len <= (eip_op_e'(new_op) == OP_READ || eip_op_e'(new_op) == OP_WRITE) ? new_len : 2'h0;
            q <= 2'h0;
            bitn <= 4'h0;
            cnt <= 2'h0;
            rxdata <= 32'h0;
        end else if (qtick) begin
            q <= q + 2'd1;
            if (q == 2'd2 && is_byte) begin
                if (bitn < 4'd8) begin
                    rxsh <= {rxsh[6:0], sda_s};
                end else begin
                    nack_q <= sda_s;
                end
            end
            if (sym_end && is_byte && bitn < 4'd8) begin
                bitn <= bitn + 4'd1;
            end else if (sym_end) begin
                bitn <= 4'h0;
                case (state)
                    H_START: state <= H_AW;
                    H_AW, H_AR: begin
                        addr_nack <= nack_q;
                        state <= nack_q ? H_STOP : (state == H_AW) ? H_WORD : H_RDATA;
                    end
                    H_WORD: begin
                        addr_nack <= nack_q;
                        state <= nack_q ? H_STOP : (op == OP_READ) ? H_RSTART : H_WDATA;
                    end
                    H_WDATA: begin
                        data_nack <= data_nack | nack_q;
                        cnt <= cnt + 2'd1;
                        if (cnt == wlast) begin
                            state <= (op == OP_PROBE) ? H_PSTART : H_STOP;   // [R10]
                        end
                    end
                    H_RSTART: state <= H_AR;
                    H_RDATA: begin
                        rxdata[{cnt, 3'b000} +: 8] <= rxsh;
                        cnt <= cnt + 2'd1;
                        state <= last ? H_STOP : H_RDATA;                    // [R8]
                    end
                    H_PSTART: state <= H_STOP;
                    H_STOP: begin
                        state <= H_IDLE;
                        busy <= 1'b0;
                        done <= 1'b1;
                    end
                    default: state <= H_IDLE;
                endcase
            end
        end
    end

endmodule // eip_host

// [core/eip_if.sv]
`timescale 1ns/1ps
interface eip_if;
    logic m_scl_o;
    logic m_scl_oe;
    logic m_sda_o;
    logic m_sda_oe;
    logic s_sda_o;
    logic s_sda_oe;
    logic scl;
    logic sda;

    // Open-drain wire: low while any enabled driver pulls low
    assign scl = ~(m_scl_oe & ~m_scl_o);
    assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

    modport master (output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe,
                    input scl, input sda);
    modport slave (output s_sda_o, output s_sda_oe, input scl, input sda);
endinterface

// [core/eip_pkg.sv]
package eip_pkg;
    // Clock and timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TWR_NS = 5000000;
    localparam int TWR_CYCLES = TWR_NS / CLK_PERIOD_NS;
    localparam int FSCL_KHZ = 400;
    localparam int SCL_PERIOD_NS = 1000000 / FSCL_KHZ;
    localparam int QTR_CYCLES = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);

    // Slave address and ID page layout
    localparam logic [3:0] TYPE_ID_PAGE = 4'hb;
    localparam int ID_PAGE_BYTES = 16;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam int ADDR_CS_BIT = 3;
    localparam int ADDR_RW_BIT = 0;
    localparam int LOCK_SELECT_BIT = 7;
    localparam int LOCK_DATA_BIT = 1;
    localparam logic [7:0] LOCK_WORD = 8'h80;
    localparam logic [3:0] LAST_OFFSET = 4'hf;

    // Controller register map
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_TXDATA = 4'h4;
    localparam logic [3:0] REG_RXDATA = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hc;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_CS_BIT = 2;
    localparam int CMD_OFS_LSB = 4;
    localparam int CMD_LEN_LSB = 8;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_ADDR_NACK = 2;
    localparam int ST_DATA_NACK = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        OP_WRITE = 2'b00,
        OP_READ = 2'b01,
        OP_LOCK = 2'b10,
        OP_PROBE = 2'b11
    } eip_op_e;
endpackage

// [tb/eeprom_id_page_lock_test.sv]
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin miscompares++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module eeprom_id_page_lock_test import eip_pkg::*;;
    // Write cycle must outlast one full address phase so the busy nack can be observed
    localparam int WR = 600;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic chip_select_pin_bit = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, id_locked, prog_busy;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd;
    int miscompares = 0;
    int compares = 0;

    always #5 aclk = ~aclk;

    eip_if link();
    eip_dev #(.WR_CYCLES(WR)) eip_dev_i (.aclk(aclk), .aresetn(aresetn), .bus(link),
        .chip_select_pin_bit(chip_select_pin_bit), .id_locked(id_locked), .prog_busy(prog_busy));
    eip_host #(.QTR(8)) eip_host_i (.aclk(aclk), .aresetn(aresetn), .bus(link),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    eip_link_props #(.WR_CYCLES(WR)) eip_link_props_i (.aclk(aclk), .aresetn(aresetn),
        .s_sda_oe(link.s_sda_oe), .scl(link.scl), .sda(link.sda), .id_locked(id_locked),
        .prog_busy(prog_busy));

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge aclk); while (!(awready === 1'b1 && wready === 1'b1));
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge aclk); while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [3:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    // Launch one transfer and wait for its completion; exp is {data_nack, addr_nack, done, busy}
    task automatic run(input logic [1:0] op, input logic cs, input logic [3:0] ofs,
                       input logic [1:0] n, input logic [3:0] exp);
        axi_wr(REG_CMD, {22'h0, n, ofs, 1'b0, cs, op});
        rd = 32'h0;
        while (rd[ST_DONE] !== 1'b1) axi_rd(REG_STATUS);
        `CHK(rd[3:0], exp)
    endtask

    task automatic wait_idle();
        do @(posedge aclk); while (prog_busy !== 1'b0);
    endtask

    task automatic t_reset();
        `CHK(id_locked, 1'b0)
        axi_rd(REG_STATUS);
        `CHK(rd[3:0], 4'h0)
        `CHK(resp, RESP_OKAY)
        axi_rd(4'h2);
        `CHK(resp, RESP_SLVERR)
        `CHK(rd, 32'h0)
        axi_wr(4'h1, 32'h0);
        `CHK(resp, RESP_SLVERR)
        $display("test reset finished");
    endtask

    task automatic t_erased();
        run(OP_READ, 1'b0, 4'ha, 2'h3, 4'b0010);
        axi_rd(REG_RXDATA);
        `CHK(rd, {4{ERASED_BYTE}})
        // A read that would run past the page end is refused and never launched
        axi_wr(REG_CMD, {22'h0, 2'h1, 4'hf, 1'b0, 1'b0, OP_READ});
        `CHK(resp, RESP_SLVERR)
        axi_rd(REG_STATUS);
        `CHK(rd[3:0], 4'b0010)
        $display("test erased finished");
    endtask

    task automatic t_chip_select();
        for (int p = 0; p < 2; p++) begin
            chip_select_pin_bit <= p[0];
            repeat (4) @(posedge aclk);
            run(OP_READ, ~p[0], 4'h0, 2'h0, 4'b0110);
            run(OP_READ, p[0], 4'h0, 2'h0, 4'b0010);
        end
        $display("test chip select finished");
    endtask

    task automatic t_write_wrap();
        axi_wr(REG_TXDATA, 32'h44332211);
        run(OP_WRITE, 1'b0, 4'he, 2'h3, 4'b0010);
        // Device is programming now, so its address goes unanswered
        run(OP_WRITE, 1'b0, 4'he, 2'h3, 4'b0110);
        wait_idle();
        run(OP_READ, 1'b0, 4'he, 2'h1, 4'b0010);
        axi_rd(REG_RXDATA);
        `CHK(rd[15:0], 16'h2211)
        run(OP_READ, 1'b0, 4'h0, 2'h1, 4'b0010);
        axi_rd(REG_RXDATA);
        `CHK(rd[15:0], 16'h4433)
        $display("test write wrap finished");
    endtask

    task automatic t_probe_unlocked();
        axi_wr(REG_TXDATA, 32'h000000aa);
        run(OP_PROBE, 1'b0, 4'h5, 2'h0, 4'b0010);
        `CHK(prog_busy, 1'b0)
        run(OP_READ, 1'b0, 4'h5, 2'h0, 4'b0010);
        axi_rd(REG_RXDATA);
        `CHK(rd[7:0], ERASED_BYTE)
        $display("test probe unlocked finished");
    endtask

    task automatic t_lock();
        axi_wr(REG_TXDATA, 32'h000000fd);
        run(OP_LOCK, 1'b0, 4'h0, 2'h0, 4'b0010);
        wait_idle();
        `CHK(id_locked, 1'b0)
        axi_wr(REG_TXDATA, 32'h00000002);
        run(OP_LOCK, 1'b0, 4'h0, 2'h0, 4'b0010);
        wait_idle();
        `CHK(id_locked, 1'b1)
        $display("test lock finished");
    endtask

    task automatic t_locked();
        axi_wr(REG_TXDATA, 32'h00000000);
        run(OP_WRITE, 1'b0, 4'he, 2'h0, 4'b1010);
        run(OP_PROBE, 1'b0, 4'h3, 2'h0, 4'b1010);
        run(OP_READ, 1'b0, 4'he, 2'h1, 4'b0010);
        axi_rd(REG_RXDATA);
        `CHK(rd[15:0], 16'h2211)
        `CHK(id_locked, 1'b1)
        $display("test locked finished");
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #1000000;
        miscompares++;
        report_and_stop();
    end

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        t_reset();
        t_erased();
        t_chip_select();
        chip_select_pin_bit <= 1'b0;
        repeat (4) @(posedge aclk);
        t_write_wrap();
        t_probe_unlocked();
        t_lock();
        t_locked();
        report_and_stop();
    end
endmodule // eeprom_id_page_lock_test

// [tb/eip_link_props.sv]
`timescale 1ns/1ps
module eip_link_props #(
    parameter int WR_CYCLES = 200
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_sda_oe,
    input wire logic scl,
    input wire logic sda,
    input wire logic id_locked,
    input wire logic prog_busy
);
    int busy_cycles;

    // Length of the current internal write cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_cycles <= 0;
        end else if (prog_busy) begin
            busy_cycles <= busy_cycles + 1;
        end else begin
            busy_cycles <= 0;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !s_sda_oe && !prog_busy)
        else $error("device active during reset");
    a_lock_sticks: assert property (id_locked |=> id_locked)
        else $error("lock state cleared");
    a_busy_no_ack: assert property (prog_busy |-> !s_sda_oe)
        else $error("device drives bus while programming");
    a_busy_length: assert property ($fell(prog_busy) |-> busy_cycles == WR_CYCLES)
        else $error("write cycle length wrong");
    a_busy_after_stop: assert property ($rose(prog_busy) |-> scl && sda)
        else $error("write cycle started with bus not idle");
    a_lock_bus_quiet: assert property ($rose(id_locked) |-> !s_sda_oe && scl)
        else $error("lock set in mid transfer");
    a_sda_change_low: assert property ($changed(s_sda_oe) |-> !scl)
        else $error("device changed sda while scl high");
    a_ack_min_width: assert property ($rose(s_sda_oe) |=> s_sda_oe[*8])
        else $error("device pulse on sda too short");
endmodule // eip_link_props
